// ==== hdl/ibd_consts.svh ====
// Constants for the inductive button detector: register offsets, field
// positions, reset values and tracking figures.
// Assumes it is included by bare name from the package and the design.
`ifndef IBD_CONSTS_SVH
`define IBD_CONSTS_SVH

// Width of one converted sample and channel count.
`define IBD_DW            16
`define IBD_NCH           4

// Register offsets on the byte register port.
`define IBD_OFS_STATUS    8'h00
`define IBD_OFS_IRQPOL    8'h11
`define IBD_OFS_LPSTEP    8'h13
`define IBD_OFS_NPSTEP    8'h15
`define IBD_OFS_HOLDGRP   8'h16
`define IBD_OFS_MARGIN    8'h18
`define IBD_OFS_TWIST     8'h19
`define IBD_OFS_GROUPS    8'h1A
`define IBD_OFS_COUNTER_SCALER     8'h1E
`define IBD_OFS_SPD0      8'h25
`define IBD_OFS_SPD12     8'h28
`define IBD_OFS_SPD3      8'h2B

// Status bit positions.
`define IBD_ST_PRESS      0
`define IBD_ST_ERROR      1
`define IBD_ST_READY      2
`define IBD_ST_CAUSE_LO   4

// Other field positions.
`define IBD_TWIST_EN      7
`define IBD_SPD2_LO       4

// Reset values.
`define IBD_MARGIN_RST    8'h20
`define IBD_IRQPOL_RST    8'h00
`define IBD_STEP_RST      8'h03
`define IBD_COUNTER_SCALER_RST     8'h00

// Threshold and tracking figures.
`define IBD_NOMINAL       128
`define IBD_NP_DIV        72
`define IBD_LP_MULT       8
`define IBD_CONT_STEP     16

`endif

// ==== hdl/ibd_detector.sv ====
// Post-processing of a four-channel inductive converter: baseline
// tracking, press thresholds, group filters, indicator and irq pins.
// Assumes the converter delivers one sample pulse per enabled channel at
// the end of each sampling window, and that the serial register engine
// turns host accesses into single-cycle byte strobes on the reg port.
`timescale 1ns/10ps
`default_nettype none
`include "ibd_consts.svh"

module ibd_detector (
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [7:0]                         reg_rdata,
  input  wire logic                          sample_valid,
  input  wire ibd_pkg::ibd_sample_t          sample,
  input  wire logic                          scan_done,
  input  wire logic                          error_valid,
  input  wire ibd_pkg::ibd_error_t           error_info,
  input  wire ibd_pkg::ibd_mode_t            mode,
  input  wire logic                          power_mode_pin,
  input  wire logic                          continuous_sampling_select,
  input  wire logic [`IBD_NCH-1:0]           chan_enable,
  output logic [7:0]                         counter_scaler,
  output logic [`IBD_NCH-1:0]                button_indicator_pin,
  output logic                               irq_pin,
  output logic signed [`IBD_DW-1:0]          channel_result [`IBD_NCH]
);
  import ibd_pkg::*;

  // --------------------------------------------------------------------
  // Local widths and helpers
  // --------------------------------------------------------------------
  // Baseline is kept in units of 1/72 count so both step formulas stay exact.
  localparam int BW = `IBD_DW + 8;

  // Tracking step in 1/72 units for one channel and one direction.
  function automatic logic signed [BW-1:0] step_of(input logic       lp,
                                                    input logic       cont,
                                                    input logic [3:0] idx,
                                                    input logic       neg,
                                                    input logic [1:0] spd);
    int s;
    s = 1 << idx;
    if (lp) begin
      s = s * `IBD_LP_MULT;
    end
    if (cont) begin
      s = `IBD_CONT_STEP;
    end
    if (neg) begin
      case (spd)
        2'h1:    s = s * 4;
        2'h2:    s = s * 8;
        2'h3:    s = s * 16;
        default: s = s;
      endcase
    end
    return BW'(s);
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0]                irqpol_q;        // Bit 0 set makes irq active high.
  logic [7:0]                lpstep_q;        // Low power increment index.
  logic [7:0]                npstep_q;        // Normal increment index.
  logic [7:0]                holdgrp_q;       // Hold bits low, strongest group high.
  logic [7:0]                margin_q;        // Press/release margin.
  logic [7:0]                twist_q;         // Enable bit 7, threshold below.
  logic [7:0]                groups_q;        // Anti-common low, anti-deform high.
  logic [7:0]                counter_scaler_q;         // Counter scaler for the converter.
  logic [7:0]                spd0_q;          // Speed-up setting channel 0.
  logic [7:0]                spd12_q;         // Speed-up settings channels 1 and 2.
  logic [7:0]                spd3_q;          // Speed-up setting channel 3.
  logic                      press_seen_q;    // Sticky first-press flag.
  logic                      error_q;         // Sticky error flag.
  logic                      ready_q;         // Raw data ready flag.
  logic [3:0]                cause_q;         // Last error cause.
  logic [`IBD_NCH-1:0]       out_q;           // Button indicator state.
  logic signed [`IBD_DW-1:0] result_q [`IBD_NCH]; // Latest result per channel.
  logic                      status_rd;       // Host read of the status register.
  logic                      lp_mode;         // Low power mode in force.
  logic                      cont_mode;       // Continuous sampling in force.
  logic [1:0]                spd [`IBD_NCH];  // Speed-up setting per channel.

  assign status_rd = reg_rd && (reg_addr == `IBD_OFS_STATUS);
  assign lp_mode = ~power_mode_pin;
  assign cont_mode = continuous_sampling_select & power_mode_pin;

  assign spd[0] = spd0_q[1:0];
  assign spd[1] = spd12_q[1:0];
  assign spd[2] = spd12_q[`IBD_SPD2_LO +: 2];
  assign spd[3] = spd3_q[1:0];

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // Plain read/write configuration; unmapped writes are dropped.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqpol_q  <= `IBD_IRQPOL_RST;
      lpstep_q  <= `IBD_STEP_RST;
      npstep_q  <= `IBD_STEP_RST;
      holdgrp_q <= 8'h00;
      margin_q  <= `IBD_MARGIN_RST;
      twist_q   <= 8'h00;
      groups_q  <= 8'h00;
      counter_scaler_q   <= `IBD_COUNTER_SCALER_RST;
      spd0_q    <= 8'h00;
      spd12_q   <= 8'h00;
      spd3_q    <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `IBD_OFS_IRQPOL:  irqpol_q  <= reg_wdata;
        `IBD_OFS_LPSTEP:  lpstep_q  <= reg_wdata;
        `IBD_OFS_NPSTEP:  npstep_q  <= reg_wdata;
        `IBD_OFS_HOLDGRP: holdgrp_q <= reg_wdata;
        `IBD_OFS_MARGIN:  margin_q  <= reg_wdata;
        `IBD_OFS_TWIST:   twist_q   <= reg_wdata;
        `IBD_OFS_GROUPS:  groups_q  <= reg_wdata;
        `IBD_OFS_COUNTER_SCALER:   counter_scaler_q   <= reg_wdata;
        `IBD_OFS_SPD0:    spd0_q    <= reg_wdata;
        `IBD_OFS_SPD12:   spd12_q   <= reg_wdata;
        `IBD_OFS_SPD3:    spd3_q    <= reg_wdata;
        default:          ;
      endcase
    end
  end

  assign counter_scaler = counter_scaler_q;

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------
  // Read data is registered and valid the cycle after the read strobe.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IBD_OFS_STATUS:  reg_rdata <= {cause_q, 1'b0, ready_q, error_q, press_seen_q};
        `IBD_OFS_IRQPOL:  reg_rdata <= irqpol_q;
        `IBD_OFS_LPSTEP:  reg_rdata <= lpstep_q;
        `IBD_OFS_NPSTEP:  reg_rdata <= npstep_q;
        `IBD_OFS_HOLDGRP: reg_rdata <= holdgrp_q;
        `IBD_OFS_MARGIN:  reg_rdata <= margin_q;
        `IBD_OFS_TWIST:   reg_rdata <= twist_q;
        `IBD_OFS_GROUPS:  reg_rdata <= groups_q;
        `IBD_OFS_COUNTER_SCALER:   reg_rdata <= counter_scaler_q;
        `IBD_OFS_SPD0:    reg_rdata <= spd0_q;
        `IBD_OFS_SPD12:   reg_rdata <= spd12_q;
        `IBD_OFS_SPD3:    reg_rdata <= spd3_q;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Per-channel processing
  // --------------------------------------------------------------------
  genvar n;
  generate
    for (n = 0; n < `IBD_NCH; n++) begin : g_ch
      logic signed [BW-1:0]      base_q;   // Baseline in 1/72 units.
      logic signed [BW-1:0]      target;   // Raw sample in 1/72 units.
      logic signed [BW-1:0]      step;     // Step for this sample.
      logic signed [BW-1:0]      gap;      // Distance from baseline to raw.
      logic signed [`IBD_DW-1:0] res_new;  // Result of this window.
      logic signed [`IBD_DW-1:0] cur [`IBD_NCH]; // Results seen by filters.
      logic                      hit;      // This sample is for channel n.
      logic                      blocked;  // A twist or group filter forbids a press.
      logic                      press;    // Press threshold reached.
      logic                      keep;     // Still above release point.
      logic                      track;    // Tracking allowed this window.
      int                        on_thr;
      int                        off_thr;

      assign hit    = sample_valid && (sample.chan == 2'(n)) && chan_enable[n];
      assign target = BW'(sample.raw) * BW'(`IBD_NP_DIV);
      assign gap    = target - base_q;
      assign res_new = `IBD_DW'(gap / BW'(`IBD_NP_DIV));
      assign step = step_of(lp_mode, cont_mode,
                            lp_mode ? lpstep_q[3:0] : npstep_q[3:0],
                            res_new < 0, spd[n]);

      // Filters look at this window's value and the others' latest values.
      always_comb begin
        int k;
        int above;
        int cnt;
        k       = 0;
        on_thr  = `IBD_NOMINAL + int'(margin_q);
        off_thr = `IBD_NOMINAL - int'(margin_q);
        blocked = 1'b0;
        above   = 0;
        cnt     = 0;
        for (k = 0; k < `IBD_NCH; k++) begin
          cur[k] = (k == n) ? res_new : result_q[k];
        end
        for (k = 0; k < `IBD_NCH; k++) begin
          if (twist_q[`IBD_TWIST_EN] && chan_enable[k] &&
              (int'(cur[k]) < -int'(twist_q[6:0]))) begin
            blocked = 1'b1;
          end
          if (groups_q[k] && chan_enable[k]) begin
            cnt = cnt + 1;
            if (int'(cur[k]) >= on_thr) begin
              above = above + 1;
            end
          end
          if (k != n && holdgrp_q[4 + n] && holdgrp_q[4 + k] && chan_enable[k] &&
              (cur[k] > cur[n] || (cur[k] == cur[n] && k < n))) begin
            blocked = 1'b1;
          end
          if (k != n && groups_q[4 + n] && out_q[k]) begin
            blocked = 1'b1;
          end
        end
        if (groups_q[n] && cnt > 1 && above == cnt) begin
          blocked = 1'b1;
        end
        press = (int'(res_new) >= on_thr) && !blocked;
        keep  = int'(res_new) > off_thr;
        track = (mode == IBD_BUTTON) && !(holdgrp_q[n] && out_q[n]);
      end

      // Baseline moves toward the raw value and never overshoots it.
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          base_q <= '0;
        end else if (hit && track) begin
          if (gap > step) begin
            base_q <= base_q + step;
          end else if (gap < -step) begin
            base_q <= base_q - step;
          end else begin
            base_q <= target;
          end
        end
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          result_q[n] <= '0;
          out_q[n]    <= 1'b0;
        end else if (mode == IBD_RAW) begin
          out_q[n] <= 1'b0;
          if (hit) begin
            result_q[n] <= res_new;
          end
        end else if (hit) begin
          result_q[n] <= res_new;
          out_q[n] <= out_q[n] ? keep : press;
        end else if (!chan_enable[n]) begin
          out_q[n] <= 1'b0;
        end
      end

      assign channel_result[n] = result_q[n];
    end
  endgenerate

  assign button_indicator_pin = out_q;

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  logic any_out;       // Some button currently asserted.
  logic any_out_q;     // Previous cycle's any_out for first-press edge.
  logic first_press;   // Transition from no button to some button.

  assign any_out     = |out_q;
  assign first_press = any_out && !any_out_q;

  // Flags set by hardware win over a clearing status read in the same cycle.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      any_out_q    <= 1'b0;
      press_seen_q <= 1'b0;
      error_q      <= 1'b0;
      ready_q      <= 1'b0;
      cause_q      <= 4'h0;
    end else begin
      any_out_q <= any_out;
      if (first_press) begin
        press_seen_q <= 1'b1;
      end else if (status_rd) begin
        press_seen_q <= 1'b0;
      end
      if (error_valid) begin
        error_q <= 1'b1;
        cause_q <= error_info.cause;
      end else if (status_rd) begin
        error_q <= 1'b0;
      end
      if (scan_done && mode == IBD_RAW) begin
        ready_q <= 1'b1;
      end else if (status_rd) begin
        ready_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt pin
  // --------------------------------------------------------------------
  // polarity and sources
  assign irq_pin = irqpol_q[0] ? (any_out | error_q | ready_q)
                               : ~(any_out | error_q | ready_q);

endmodule
`default_nettype wire

// ==== hdl/ibd_pkg.sv ====
// Types shared by the inductive button detector.
// Assumes ibd_consts.svh is on the include path.
`include "ibd_consts.svh"

package ibd_pkg;

  // One converted sample handed over at the end of a sampling window.
  typedef struct packed {
    logic [1:0]                     chan;
    logic signed [`IBD_DW-1:0]      raw;
  } ibd_sample_t;

  // Error report from the converter.
  typedef struct packed {
    logic [3:0] cause;
  } ibd_error_t;

  // Operating mode of the post-processing.
  typedef enum logic {
    IBD_BUTTON,
    IBD_RAW
  } ibd_mode_t;

endpackage

// ==== tb/ibd_conv_model.sv ====
// Converter model feeding samples, scan-complete and error pulses.
// Assumes its tasks are called at a falling clock edge by the bench.
`timescale 1ns/10ps
`default_nettype none
module ibd_conv_model (
  input  wire logic                ref_clk,
  output var logic                 sample_valid,
  output var ibd_pkg::ibd_sample_t sample,
  output var logic                 scan_done,
  output var logic                 error_valid,
  output var ibd_pkg::ibd_error_t  error_info
);
  import ibd_pkg::*;

  // Idle levels; data lines never rest on a stale copy of real data.
  initial begin
    sample_valid = 1'b0;
    sample       = '1;
    scan_done    = 1'b0;
    error_valid  = 1'b0;
    error_info   = '1;
  end

  task automatic send_sample(input logic [1:0] ch, input logic [15:0] raw);
    sample_valid = 1'b1;
    sample       = {ch, raw};
    @(negedge ref_clk);
    sample_valid = 1'b0;
    sample       = ~{ch, raw};
  endtask

  // Scan-complete pulse of one cycle.
  task automatic pulse_scan();
    scan_done = 1'b1;
    @(negedge ref_clk);
    scan_done = 1'b0;
  endtask

  // Error pulse; the cause is inverted once the pulse is over.
  task automatic pulse_error(input logic [3:0] cause);
    error_valid = 1'b1;
    error_info  = cause;
    @(negedge ref_clk);
    error_valid = 1'b0;
    error_info  = ~cause;
  endtask
endmodule
`default_nettype wire

// ==== tb/ibd_detector_asserts.sv ====
// Port checker for the inductive button detector.
// Assumes it is bound to ibd_detector and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "ibd_consts.svh"
module ibd_detector_asserts (
  input wire logic                         ref_clk,
  input wire logic                         sys_rst,
  input wire logic [7:0]                   reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [7:0]                   reg_rdata,
  input wire logic                         sample_valid,
  input wire ibd_pkg::ibd_sample_t         sample,
  input wire logic                         scan_done,
  input wire logic                         error_valid,
  input wire ibd_pkg::ibd_mode_t           mode,
  input wire logic [`IBD_NCH-1:0]          chan_enable,
  input wire logic [`IBD_NCH-1:0]          button_indicator_pin,
  input wire logic                         irq_pin,
  input wire logic signed [`IBD_DW-1:0]    channel_result [`IBD_NCH]
);
  import ibd_pkg::*;

  // ----------------------------------------------------------------
  // Register mirrors
  // ----------------------------------------------------------------
  logic [7:0] margin_q;  // Copy of the margin register.
  logic       pol_q;     // Copy of the irq polarity bit.
  logic       filt_q;    // Sticky: a press filter was ever switched on.
  int         thr_on;    // Press point.
  int         thr_off;   // Release point.

  assign thr_on  = 128 + int'(margin_q);
  assign thr_off = 128 - int'(margin_q);

  // Track margin and polarity writes so checks follow the live setting.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      margin_q <= `IBD_MARGIN_RST;
      pol_q    <= 1'b0;
    end else if (reg_wr && reg_addr == `IBD_OFS_MARGIN) begin
      margin_q <= reg_wdata;
    end else if (reg_wr && reg_addr == `IBD_OFS_IRQPOL) begin
      pol_q <= reg_wdata[0];
    end
  end

  // Filters may legally block a press, so the press check stands down once
  // any of them has been enabled; this trades coverage for no false alarms.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_q <= 1'b0;
    end else if (reg_wr && ((reg_addr == `IBD_OFS_TWIST && reg_wdata[7])
                 || (reg_addr == `IBD_OFS_GROUPS && reg_wdata != 8'h00)
                 || (reg_addr == `IBD_OFS_HOLDGRP && reg_wdata[7:4] != 4'h0))) begin
      filt_q <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // press at threshold
  AST_PRESS_POINT: assert property (
    sample_valid && chan_enable[sample.chan] && mode == IBD_BUTTON && !filt_q |=>
    !(channel_result[$past(sample.chan)] >= thr_on) || button_indicator_pin[$past(sample.chan)])
    else $error("indicator not raised at press point");
  AST_RELEASE_POINT: assert property (
    sample_valid && chan_enable[sample.chan] && mode == IBD_BUTTON |=>
    !(channel_result[$past(sample.chan)] <= thr_off) || !button_indicator_pin[$past(sample.chan)])
    else $error("indicator not dropped at release point");
  AST_RAW_NO_INDICATOR: assert property (
    mode == IBD_RAW ##1 mode == IBD_RAW |-> button_indicator_pin == '0)
    else $error("indicator driven in raw mode");
  AST_IRQ_WHILE_PRESSED: assert property (
    |button_indicator_pin |-> irq_pin == pol_q)
    else $error("irq inactive while a button is pressed");
  AST_INDICATOR_HOLDS: assert property (
    !sample_valid && mode == IBD_BUTTON && $stable(chan_enable) ##1
    mode == IBD_BUTTON && $stable(chan_enable) |->
    button_indicator_pin == $past(button_indicator_pin))
    else $error("indicator changed without a sample");
  AST_ERROR_IRQ: assert property (
    error_valid |=> irq_pin == pol_q)
    else $error("irq not raised after error");
  AST_READY_IRQ: assert property (
    scan_done && mode == IBD_RAW |=> irq_pin == pol_q)
    else $error("irq not raised after raw scan");
  AST_MARGIN_READBACK: assert property (
    reg_rd && !reg_wr && reg_addr == `IBD_OFS_MARGIN |=> reg_rdata == margin_q)
    else $error("margin readback wrong");

  COV_PRESS: cover property (sample_valid ##1 |button_indicator_pin);
  COV_ERROR: cover property (error_valid ##1 irq_pin == pol_q);
  COV_RAW_READY: cover property (scan_done && mode == IBD_RAW);
endmodule
`default_nettype wire

// ==== tb/ibd_detector_test.sv ====
// Self-checking bench for the detector, with a converter model.
// Assumes the package and the constants header compile first.
`timescale 1ns/10ps
`default_nettype none
`include "ibd_consts.svh"
module ibd_detector_test;
  import ibd_pkg::*;
  logic                     ref_clk;
  logic                     sys_rst;
  logic [7:0]               reg_addr;
  logic [7:0]               reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [7:0]               reg_rdata;
  logic [7:0]               counter_scaler;
  logic                     sample_valid;
  ibd_sample_t              sample;
  logic                     scan_done;
  logic                     error_valid;
  ibd_error_t               error_info;
  ibd_mode_t                mode;
  logic                     power_mode_pin;
  logic                     continuous_sampling_select;
  logic [3:0]               chan_enable;
  logic [3:0]               button_indicator_pin;
  logic                     irq_pin;
  logic signed [15:0]       channel_result [4];
  int                       bad_count;
  int                       cmp_count;
  int                       cycles;
  int                       base [4];    // Expected baseline, in 1/72 units.
  logic [1:0]               spd [4];     // Expected speed-up codes.
  logic [3:0]               ind;         // Expected indicators.
  logic [3:0]               hold;        // Expected hold bits.
  logic                     pol;         // Expected polarity bit.
  int                       np_idx;
  int                       lp_idx;
  int                       margin;

  ibd_detector ibd_detector_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .sample(sample), .scan_done(scan_done),
    .error_valid(error_valid), .error_info(error_info), .mode(mode),
    .power_mode_pin(power_mode_pin), .continuous_sampling_select(continuous_sampling_select),
    .chan_enable(chan_enable), .counter_scaler(counter_scaler),
    .button_indicator_pin(button_indicator_pin), .irq_pin(irq_pin),
    .channel_result(channel_result));
  ibd_conv_model ibd_conv_model_inst (.ref_clk(ref_clk), .sample_valid(sample_valid),
    .sample(sample), .scan_done(scan_done), .error_valid(error_valid),
    .error_info(error_info));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  // The whole run needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("TB: compared %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic irq(input logic act);
    chk("irq_pin", {15'h0000, ~(act ^ pol)}, {15'h0000, irq_pin});
  endtask

  // Strobes drop at the next falling edge; a spare cycle avoids re-raising
  // them in the same time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    @(negedge ref_clk);
  endtask

  // Sends one sample; blk says a filter must stop a new press.
  task automatic send(input int ch, input int raw, input logic blk);
    int r;
    int st;
    int d;
    r  = (raw * 72 - base[ch]) / 72;
    d  = raw * 72 - base[ch];
    st = (power_mode_pin && continuous_sampling_select) ? 16 :
         power_mode_pin ? (1 << np_idx) : 8 * (1 << lp_idx);
    if (r < 0 && spd[ch] != 2'b00) st = st * (2 << spd[ch]);
    if (mode == IBD_BUTTON && !(hold[ch] && ind[ch])) base[ch] += (d > st) ? st : (d < -st) ? -st : d;
    if (mode == IBD_RAW) ind[ch] = 1'b0;
    else if (r >= 128 + margin && !blk) ind[ch] = 1'b1;
    else if (r <= 128 - margin) ind[ch] = 1'b0;
    ibd_conv_model_inst.send_sample(ch[1:0], raw[15:0]);
    chk("channel_result", r[15:0], channel_result[ch]);
    chk("button_indicator_pin", {12'h000, ind}, {12'h000, button_indicator_pin});
    @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    mode = IBD_BUTTON;
    power_mode_pin = 1'b1;
    continuous_sampling_select = 1'b0;
    chan_enable = 4'hF;
    {bad_count, cmp_count, cycles} = '0;
    {np_idx, lp_idx, margin} = {32'd3, 32'd3, 32'd32};
    {pol, hold, ind} = '0;
    foreach (base[i]) {base[i], spd[i]} = '0;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    irq(1'b0);
    rd(`IBD_OFS_MARGIN, `IBD_MARGIN_RST);
    rd(`IBD_OFS_NPSTEP, `IBD_STEP_RST);
    rd(8'h05, 8'h00);
    wr(`IBD_OFS_COUNTER_SCALER, 8'h05);
    chk("counter_scaler", 16'h0005, {8'h00, counter_scaler});
    send(0, 160, 1'b0);
    irq(1'b1);
    rd(`IBD_OFS_STATUS, 8'h01);
    rd(`IBD_OFS_STATUS, 8'h00);
    send(1, 250, 1'b0);
    rd(`IBD_OFS_STATUS, 8'h00);
    wr(`IBD_OFS_HOLDGRP, 8'h01);
    hold = 4'h1;
    repeat (3) send(0, 300, 1'b0);
    wr(`IBD_OFS_HOLDGRP, 8'h00);
    hold = 4'h0;
    send(0, 0, 1'b0);
    irq(1'b1);
    send(1, 0, 1'b0);
    irq(1'b0);
    wr(`IBD_OFS_MARGIN, 8'h0A);
    margin = 10;
    send(2, 138, 1'b0);
    send(2, 125, 1'b0);
    send(2, 119, 1'b0);
    rd(`IBD_OFS_STATUS, 8'h01);
    wr(`IBD_OFS_NPSTEP, 8'h05);
    np_idx = 5;
    wr(`IBD_OFS_LPSTEP, 8'h02);
    lp_idx = 2;
    for (int s = 0; s < 4; s++) begin
      wr(`IBD_OFS_SPD3, s[7:0]);
      spd[3] = s[1:0];
      repeat (2) send(3, -300, 1'b0);
    end
    power_mode_pin = 1'b0;
    repeat (2) send(3, -250, 1'b0);
    continuous_sampling_select = 1'b1;
    send(3, -250, 1'b0);
    power_mode_pin = 1'b1;
    repeat (2) send(3, -250, 1'b0);
    continuous_sampling_select = 1'b0;
    wr(`IBD_OFS_TWIST, 8'hB2);
    send(1, 400, 1'b1);
    wr(`IBD_OFS_TWIST, 8'h00);
    wr(`IBD_OFS_HOLDGRP, 8'h30);
    send(0, 300, 1'b1);
    send(1, 400, 1'b0);
    wr(`IBD_OFS_HOLDGRP, 8'h00);
    wr(`IBD_OFS_GROUPS, 8'h45);
    send(2, 300, 1'b1);
    send(0, 300, 1'b1);
    wr(`IBD_OFS_GROUPS, 8'h00);
    send(1, 0, 1'b0);
    rd(`IBD_OFS_STATUS, 8'h01);
    mode = IBD_RAW;
    repeat (2) send(0, 500, 1'b0);
    ibd_conv_model_inst.pulse_scan();
    irq(1'b1);
    rd(`IBD_OFS_STATUS, 8'h04);
    irq(1'b0);
    mode = IBD_BUTTON;
    ibd_conv_model_inst.pulse_error(4'hA);
    irq(1'b1);
    rd(`IBD_OFS_STATUS, 8'hA2);
    irq(1'b0);
    wr(`IBD_OFS_IRQPOL, 8'h01);
    pol = 1'b1;
    irq(1'b0);
    send(3, 400, 1'b0);
    irq(1'b1);
    end_of_test();
  end
endmodule

bind ibd_detector ibd_detector_asserts ibd_detector_asserts_inst (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample(sample),
  .scan_done(scan_done), .error_valid(error_valid), .mode(mode), .chan_enable(chan_enable),
  .button_indicator_pin(button_indicator_pin), .irq_pin(irq_pin),
  .channel_result(channel_result));
`default_nettype wire
